// File: btpc_consts.svh
// constants for the branch target and program counter logic
// assumes inclusion by bare name from the package and the design files
`ifndef BTPC_CONSTS_SVH
`define BTPC_CONSTS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define BTPC_PC_W          16
`define BTPC_LEN_W         3
`define BTPC_INDEX_W       5

// ----------------------------------------
// reset values and fixed fields
// ----------------------------------------
`define BTPC_PC_RESET      16'h0000
`define BTPC_SHORT_PAGE    5'h01
`define BTPC_TABLE_BASE    16'h0040
`define BTPC_TABLE_LSB     1
`define BTPC_TABLE_MSB     5

// ----------------------------------------
// timing
// ----------------------------------------
`define BTPC_FETCH_MAX     64

`endif

// File: btpc_pkg.sv
// types and helper functions of the branch target and program counter logic
// assumes btpc_consts.svh is on the include path
`include "btpc_consts.svh"

package btpc_pkg;

   // ----------------------------------------
   // modes from the decoder
   // ----------------------------------------
   typedef enum logic [2:0] {
      btpc_mode_seq,
      btpc_mode_rel,
      btpc_mode_abs,
      btpc_mode_short,
      btpc_mode_table,
      btpc_mode_reg
   } btpc_mode_t;

   typedef enum logic [1:0] {
      btpc_fetch_idle,
      btpc_fetch_lo,
      btpc_fetch_hi
   } btpc_fetch_state_t;

   // ----------------------------------------
   // module state
   // ----------------------------------------
   typedef struct packed {
      logic [`BTPC_PC_W-1:0]    pc;
      logic                     pc_valid;
      logic                     busy;
      logic                     start;
      logic [`BTPC_INDEX_W-1:0] index;
   } btpc_core_state_t;

   typedef struct packed {
      btpc_fetch_state_t     state;
      logic [`BTPC_PC_W-1:0] addr;
      logic                  req;
      logic [7:0]            lo;
      logic                  done;
      logic [`BTPC_PC_W-1:0] entry;
   } btpc_fetch_st_t;

   // ----------------------------------------
   // functions
   // ----------------------------------------
   function automatic logic [`BTPC_PC_W-1:0] btpc_sext8(input logic [7:0] d);
      btpc_sext8 = {{(`BTPC_PC_W-8){d[7]}}, d};
   endfunction

   function automatic logic [`BTPC_PC_W-1:0] btpc_table_addr(input logic [`BTPC_INDEX_W-1:0] idx);
      btpc_table_addr = `BTPC_TABLE_BASE + {10'h000, idx, 1'b0};
   endfunction

endpackage

// File: btpc_fetch_if.sv
// carrier between the core and its table fetch unit
// assumes both ends run on the same clock
`timescale 1ns/1ns
`include "btpc_consts.svh"

interface btpc_fetch_if;
   logic                     start;
   logic [`BTPC_INDEX_W-1:0] index;
   logic                     done;
   logic [`BTPC_PC_W-1:0]    entry;

   modport core (output start, output index, input done, input entry);
   modport fetcher (input start, input index, output done, output entry);
endinterface

// File: btpc_table_fetch.sv
// table entry fetch: reads a 16-bit entry as two bytes from program memory
// assumes memory answers each request with one mem_rvalid pulse, later
`timescale 1ns/1ns
`include "btpc_consts.svh"

module btpc_table_fetch (
   input  wire logic            clk,
   input  wire logic            rst,
   btpc_fetch_if.fetcher        f,
   output logic                 mem_req,
   output logic [15:0]          mem_addr,
   input  wire logic [7:0]      mem_rdata,
   input  wire logic            mem_rvalid
);

   btpc_pkg::btpc_fetch_st_t s;
   btpc_pkg::btpc_fetch_st_t next_s;

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_comb begin
      next_s      = s;
      next_s.req  = 1'b0;
      next_s.done = 1'b0;
      case (s.state)
         btpc_pkg::btpc_fetch_idle: begin
            if (f.start) begin
               next_s.addr  = btpc_pkg::btpc_table_addr(f.index);
               next_s.req   = 1'b1;
               next_s.state = btpc_pkg::btpc_fetch_lo;
            end
         end
         btpc_pkg::btpc_fetch_lo: begin
            if (mem_rvalid) begin
               next_s.lo    = mem_rdata;
               next_s.addr  = s.addr + 16'h0001;
               next_s.req   = 1'b1;
               next_s.state = btpc_pkg::btpc_fetch_hi;
            end
         end
         btpc_pkg::btpc_fetch_hi: begin
            if (mem_rvalid) begin
               next_s.entry = {mem_rdata, s.lo};
               next_s.done  = 1'b1;
               next_s.state = btpc_pkg::btpc_fetch_idle;
            end
         end
         default: next_s.state = btpc_pkg::btpc_fetch_idle;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign mem_req  = s.req;
   assign mem_addr = s.addr;
   assign f.done   = s.done;
   assign f.entry  = s.entry;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence lo_byte_s;
      mem_req && !mem_addr[0];
   endsequence

   sequence hi_byte_s;
      mem_req && mem_addr[0];
   endsequence

   property first_read_p;
      @(posedge clk) disable iff (rst)
      (f.start && s.state == btpc_pkg::btpc_fetch_idle) |=>
         lo_byte_s ##0 (mem_addr == btpc_pkg::btpc_table_addr($past(f.index)));
   endproperty

   property second_read_p;
      @(posedge clk) disable iff (rst)
      (s.state == btpc_pkg::btpc_fetch_lo && mem_rvalid) |=>
         hi_byte_s ##0 (mem_addr == $past(mem_addr) + 16'h0001);
   endproperty

   table_low_read_a: assert property (first_read_p) else $error("table low byte address wrong");
   table_high_read_a: assert property (second_read_p) else $error("table high byte address wrong");
   table_entry_order_a: assert property (@(posedge clk) disable iff (rst)
      (s.state == btpc_pkg::btpc_fetch_hi && mem_rvalid) |=>
         f.done && f.entry == {$past(mem_rdata), $past(s.lo)})
      else $error("table entry byte order wrong");

endmodule // btpc_table_fetch

// File: btpc_core.sv
// program counter next-address logic of an 8-bit core
// assumes the decoder holds issue only while busy is low and drives all fields with it
`timescale 1ns/1ns
`include "btpc_consts.svh"

module btpc_core #(
   parameter int FETCH_MAX = `BTPC_FETCH_MAX
) (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      issue,
   input  wire btpc_pkg::btpc_mode_t      mode,
   input  wire logic [`BTPC_LEN_W-1:0]    instr_len,
   input  wire logic                      cond_taken,
   input  wire logic [7:0]                relative_displacement,
   input  wire logic [`BTPC_PC_W-1:0]     imm_addr,
   input  wire logic [10:0]               short_call_field,
   input  wire logic [7:0]                opcode,
   input  wire logic [`BTPC_PC_W-1:0]     accumulator_pair,
   input  wire logic [7:0]                mem_rdata,
   input  wire logic                      mem_rvalid,
   output logic [`BTPC_PC_W-1:0]          program_counter,
   output logic                           pc_valid,
   output logic                           busy,
   output logic                           mem_req,
   output logic [`BTPC_PC_W-1:0]          mem_addr
);

   btpc_pkg::btpc_core_state_t s;
   btpc_pkg::btpc_core_state_t next_s;
   btpc_fetch_if               fif ();

   logic                       take;
   logic [`BTPC_PC_W-1:0]      seq_addr;
   logic [`BTPC_PC_W-1:0]      rel_addr;

   // ----------------------------------------
   // address arithmetic
   // ----------------------------------------
   assign take     = issue && !s.busy;
   assign seq_addr = s.pc + {13'h0000, instr_len};
   assign rel_addr = seq_addr + btpc_pkg::btpc_sext8(relative_displacement);

   // ----------------------------------------
   // next program counter
   // ----------------------------------------
   always_comb begin
      next_s          = s;
      next_s.pc_valid = 1'b0;
      next_s.start    = 1'b0;
      if (s.busy) begin
         if (fif.done) begin
            next_s.pc       = fif.entry;
            next_s.pc_valid = 1'b1;
            next_s.busy     = 1'b0;
         end
      end else if (issue) begin
         next_s.pc_valid = 1'b1;
         case (mode)
            btpc_pkg::btpc_mode_seq: begin
               next_s.pc = seq_addr;
            end
            btpc_pkg::btpc_mode_rel: begin
               next_s.pc = cond_taken ? rel_addr : seq_addr;
            end
            btpc_pkg::btpc_mode_abs: begin
               next_s.pc = imm_addr;
            end
            btpc_pkg::btpc_mode_short: begin
               next_s.pc = {`BTPC_SHORT_PAGE, short_call_field};
            end
            btpc_pkg::btpc_mode_table: begin
               next_s.pc_valid = 1'b0;
               next_s.busy     = 1'b1;
               next_s.start    = 1'b1;
               next_s.index    = opcode[`BTPC_TABLE_MSB:`BTPC_TABLE_LSB];
            end
            btpc_pkg::btpc_mode_reg: begin
               next_s.pc = accumulator_pair;
            end
            default: begin
               next_s.pc = seq_addr;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s    <= '0;
         s.pc <= `BTPC_PC_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign fif.start = s.start;
   assign fif.index = s.index;

   // ----------------------------------------
   // table fetch unit
   // ----------------------------------------
   btpc_table_fetch u_fetch (
      .clk        (clk),
      .rst        (rst),
      .f          (fif),
      .mem_req    (mem_req),
      .mem_addr   (mem_addr),
      .mem_rdata  (mem_rdata),
      .mem_rvalid (mem_rvalid)
   );

   assign program_counter = s.pc;
   assign pc_valid        = s.pc_valid;
   assign busy            = s.busy;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence table_issue_s;
      take && mode == btpc_pkg::btpc_mode_table;
   endsequence

   sequence table_done_s;
      busy && !pc_valid ##[4:1000] pc_valid;
   endsequence

   seq_advance_a: assert property (@(posedge clk) disable iff (rst)
      (take && mode == btpc_pkg::btpc_mode_seq) |=>
         pc_valid && program_counter == $past(program_counter) + {13'h0000, $past(instr_len)})
      else $error("sequential advance wrong");

   rel_target_a: assert property (@(posedge clk) disable iff (rst)
      (take && mode == btpc_pkg::btpc_mode_rel && cond_taken) |=>
         program_counter == $past(rel_addr) && pc_valid)
      else $error("relative target wrong");

   rel_sign_a: assert property (@(posedge clk) disable iff (rst)
      (take && mode == btpc_pkg::btpc_mode_rel && cond_taken && relative_displacement[7]) |=>
         program_counter == $past(seq_addr) - {8'h00, ~$past(relative_displacement)} - 16'h0001)
      else $error("negative displacement not sign extended");

   rel_untaken_a: assert property (@(posedge clk) disable iff (rst)
      (take && mode == btpc_pkg::btpc_mode_rel && !cond_taken) |=>
         program_counter == $past(seq_addr))
      else $error("untaken branch did not fall through");

   abs_load_a: assert property (@(posedge clk) disable iff (rst)
      (take && mode == btpc_pkg::btpc_mode_abs) |=> program_counter == $past(imm_addr))
      else $error("absolute target wrong");

   short_field_a: assert property (@(posedge clk) disable iff (rst)
      (take && mode == btpc_pkg::btpc_mode_short) |=> program_counter[10:0] == $past(short_call_field))
      else $error("short call field wrong");

   short_page_a: assert property (@(posedge clk) disable iff (rst)
      (take && mode == btpc_pkg::btpc_mode_short) |=> program_counter[15:11] == 5'h01)
      else $error("short call page wrong");

   table_call_a: assert property (@(posedge clk) disable iff (rst)
      table_issue_s |=> mem_req == 1'b0 ##1 mem_req &&
         mem_addr == 16'h0040 + {10'h000, $past(opcode[5:1], 2), 1'b0})
      else $error("table call index wrong");

   table_finish_a: assert property (@(posedge clk) disable iff (rst)
      table_issue_s |=> table_done_s)
      else $error("table call never completed");

   reg_branch_a: assert property (@(posedge clk) disable iff (rst)
      (take && mode == btpc_pkg::btpc_mode_reg) |=> program_counter == $past(accumulator_pair) ##1 !busy)
      else $error("register branch target wrong");

endmodule // btpc_core

// File: btpc_mem_model.sv
// program memory model answering byte reads of the table fetch
// assumes one mem_req pulse per read and a delay of at least 1
`timescale 1ns/1ns

module btpc_mem_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [3:0]  delay,
   input  wire logic        mem_req,
   input  wire logic [15:0] mem_addr,
   output logic [7:0]       mem_rdata,
   output logic             mem_rvalid
);
   logic [15:0] addr;
   logic [3:0]  cnt;

   // data stands only with the pulse; otherwise it toggles
   always_ff @(posedge clk) begin
      mem_rvalid <= 1'b0;
      mem_rdata  <= ~mem_rdata;
      if (rst) begin
         cnt       <= 4'h0;
         mem_rdata <= 8'h00;
      end else if (mem_req) begin
         addr <= mem_addr;
         cnt  <= delay;
      end else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
         if (cnt == 4'h1) begin
            mem_rvalid <= 1'b1;
            mem_rdata  <= addr[7:0] ^ addr[15:8] ^ 8'h5A;
         end
      end
   end
endmodule // btpc_mem_model

// File: branch_target_pc_logic_test.sv
// self-checking bench of the program counter next-address logic
// assumes btpc_consts.svh on the include path and the memory model beside it
`timescale 1ns/1ns
`include "btpc_consts.svh"

module branch_target_pc_logic_test;
   logic                  clk = 1'b0;
   logic                  rst = 1'b1;
   logic                  issue = 1'b0;
   btpc_pkg::btpc_mode_t  mode = btpc_pkg::btpc_mode_seq;
   logic [2:0]            instr_len = 3'h0;
   logic                  cond_taken = 1'b0;
   logic [15:0]           val = 16'h0000;
   logic [3:0]            delay = 4'h1;
   logic [7:0]            mem_rdata;
   logic                  mem_rvalid;
   logic [15:0]           program_counter;
   logic                  pc_valid;
   logic                  busy;
   logic                  mem_req;
   logic [15:0]           mem_addr;
   logic [15:0]           exp_pc;
   int                    failures = 0;
   int                    samples_checked = 0;
   int                    cycles = 0;

   always #20 clk = ~clk;

   btpc_core u_btpc_core (
      .clk(clk), .rst(rst), .issue(issue), .mode(mode), .instr_len(instr_len),
      .cond_taken(cond_taken), .relative_displacement(val[7:0]), .imm_addr(val),
      .short_call_field(val[10:0]), .opcode(val[7:0]), .accumulator_pair(val),
      .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .program_counter(program_counter),
      .pc_valid(pc_valid), .busy(busy), .mem_req(mem_req), .mem_addr(mem_addr)
   );

   btpc_mem_model u_btpc_mem_model (
      .clk(clk), .rst(rst), .delay(delay), .mem_req(mem_req), .mem_addr(mem_addr),
      .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid)
   );

   function automatic logic [7:0] eb(input logic [15:0] a);
      eb = a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction

   task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (e !== g) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask

   // ----------------------------------------
   // one decoder request, then wait for the update
   // ----------------------------------------
   task automatic op(input btpc_pkg::btpc_mode_t m, input logic [15:0] v, input logic [2:0] l, input logic c);
      int n;
      n = 0;
      @(posedge clk);
      issue      <= 1'b1;
      mode       <= m;
      val        <= v;
      instr_len  <= l;
      cond_taken <= c;
      @(posedge clk);
      issue <= 1'b0;
      while (n < 60) begin
         #1;
         if (pc_valid === 1'b1) break;
         @(posedge clk);
         n++;
      end
      check("pc_valid", 16'h0001, {15'h0000, pc_valid});
      check("program_counter", exp_pc, program_counter);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      check("reset pc", 16'h0000, program_counter);
      check("reset flags", 16'h0000, {13'h0000, pc_valid, busy, mem_req});
      check("reset addr", 16'h0000, mem_addr);
   endtask

   task automatic t_seq();
      exp_pc = 16'h0001;
      op(btpc_pkg::btpc_mode_seq, 16'h0000, 3'h1, 1'b0);
      exp_pc = 16'h0008;
      op(btpc_pkg::btpc_mode_seq, 16'h0000, 3'h7, 1'b0);
   endtask

   task automatic t_abs_rel();
      exp_pc = 16'h1234;
      op(btpc_pkg::btpc_mode_abs, 16'h1234, 3'h3, 1'b0);
      exp_pc = 16'h1234 + 16'h0002 + 16'h007F;
      op(btpc_pkg::btpc_mode_rel, 16'h007F, 3'h2, 1'b1);
      exp_pc = exp_pc + 16'h0003 - 16'h0080;
      op(btpc_pkg::btpc_mode_rel, 16'h0080, 3'h3, 1'b1);
      exp_pc = exp_pc + 16'h0002;
      op(btpc_pkg::btpc_mode_rel, 16'h0080, 3'h2, 1'b0);
   endtask

   task automatic t_short_reg();
      exp_pc = 16'h0FFF;
      op(btpc_pkg::btpc_mode_short, 16'hFFFF, 3'h2, 1'b0);
      exp_pc = 16'h0923;
      op(btpc_pkg::btpc_mode_short, 16'h0123, 3'h2, 1'b0);
      exp_pc = 16'hBEEF;
      op(btpc_pkg::btpc_mode_reg, 16'hBEEF, 3'h1, 1'b0);
   endtask

   task automatic t_table(input logic [7:0] opc, input logic [3:0] d);
      logic [15:0] a;
      a      = 16'h0040 + {10'h000, opc[5:1], 1'b0};
      delay <= d;
      exp_pc = {eb(a + 16'h0001), eb(a)};
      op(btpc_pkg::btpc_mode_table, {8'h00, opc}, 3'h1, 1'b0);
      check("busy after entry", 16'h0000, {15'h0000, busy});
      check("last mem_addr", a + 16'h0001, mem_addr);
   endtask

   task automatic t_back_to_back();
      @(posedge clk);
      issue     <= 1'b1;
      mode      <= btpc_pkg::btpc_mode_seq;
      instr_len <= 3'h2;
      @(posedge clk);
      instr_len <= 3'h3;
      #1;
      check("first step", exp_pc + 16'h0002, program_counter);
      @(posedge clk);
      issue <= 1'b0;
      #1;
      check("second step", exp_pc + 16'h0005, program_counter);
      check("valid run", 16'h0001, {15'h0000, pc_valid});
      exp_pc = exp_pc + 16'h0005;
   endtask

   // ----------------------------------------
   // verdict
   // ----------------------------------------
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         wrap_up();
      end
   end

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      #1;
      t_reset();
      t_seq();
      t_abs_rel();
      t_short_reg();
      t_table(8'h81, 4'h1);
      t_table(8'h3E, 4'h5);
      t_back_to_back();
      wrap_up();
   end
endmodule // branch_target_pc_logic_test
